// ---- src/smc_pkg.sv ----
package smc_pkg;

    // ------------------------------------------------------------------
    // register offsets (five-bit management register address)
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_ID_HIGH = 5'h02;
    localparam logic [4:0] REG_ID_LOW = 5'h03;
    localparam logic [4:0] REG_EXT_STATUS = 5'h0f;
    localparam logic [4:0] REG_LANE_EN = 5'h10;
    localparam logic [4:0] REG_GLOBAL_CFG = 5'h11;
    localparam logic [4:0] REG_BOOST_AB = 5'h12;

    // ------------------------------------------------------------------
    // reset values and writable-bit masks
    // ------------------------------------------------------------------
    localparam logic [15:0] LANE_EN_RESET = 16'hff00;
    localparam logic [15:0] GLOBAL_CFG_RESET = 16'h4380;
    localparam logic [15:0] BOOST_AB_RESET = 16'h0dbc;
    localparam logic [15:0] EXT_STATUS_VALUE = 16'h0000;
    localparam logic [15:0] LANE_EN_WMASK = 16'hff00;
    localparam logic [15:0] GLOBAL_CFG_WMASK = 16'hc3f8;
    localparam logic [15:0] BOOST_AB_WMASK = 16'h0fff;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int LANE_LSB = 8;
    localparam int CFG_TX_STYLE = 15;
    localparam int CFG_CODE_ERR = 14;
    localparam int CFG_OUT_GATE = 9;
    localparam int CFG_COMMA = 8;
    localparam int CFG_CODING = 7;
    localparam int CFG_PIN_MODE_OVERRIDE = 6;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_SOFT_CLR = 3;
    localparam int BOOST_LSB = 10;
    localparam int BOOST_OVR = 9;
    localparam int FILL_LSB = 0;

    // ------------------------------------------------------------------
    // management frame constants
    // ------------------------------------------------------------------
    localparam logic [5:0] PREAMBLE_BITS = 6'd32;
    localparam logic [3:0] HEADER_LAST = 4'd11;
    localparam logic [3:0] DATA_LAST = 4'd15;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    typedef enum logic [2:0] {
        PH_PREAMBLE,
        PH_START,
        PH_HEADER,
        PH_TURN,
        PH_READ,
        PH_WRITE
    } smc_phase_t;

    // external strap and enable pins
    typedef struct packed {
        logic enable_pin;
        logic tx_clock_select_pin;
        logic code_error_report_pin;
        logic coding_select_pin;
        logic [1:0] mode_pins;
    } smc_pins_t;

    // effective controls driven to the datapath
    typedef struct packed {
        logic [7:0] lane_on;
        logic tx_individual_clock;
        logic code_error_report;
        logic par_out_en;
        logic comma_search_en;
        logic coding_en;
        logic [1:0] if_mode;
        logic [1:0] boost_ab;
        logic boost_override_ab;
        logic [8:0] fill_symbol_ab;
        logic logic_clear;
    } smc_ctrl_t;

    typedef struct packed {
        logic mdc_prev;
        smc_phase_t phase;
        logic [5:0] cnt;
        logic [11:0] hdr;
        logic [15:0] shift;
        logic rd_hit;
        logic wr_hit;
        logic [15:0] lane_en;
        logic [15:0] gcfg;
        logic [15:0] boost;
        logic mdio_out;
        logic mdio_oe;
        smc_ctrl_t ctl;
    } smc_state_t;

endpackage : smc_pkg

// ---- src/smc_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// R1 - id register 0x02 returns fixed identifier bits
// R2 - id 0x03: identifier, model, revision, read-only
// R3 - extended status reads zero, writes dropped
// R4 - lane enable bits 15:8, reset to ones
// R5 - lane on only when bit and pin
// R6 - station avoids lane changes during traffic
// R7 - reserved bits read zero, writes ignored
// R8 - tx clock style bit ORed with pin
// R9 - code error report bit ORed, resets one
// R10 - parallel outputs need gate bit and pin
// R11 - alignment symbol search bit, resets one
// R12 - line coding bit ORed with pin, resets one
// R13 - override bit picks register mode over pins
// R14 - soft clear resets datapath, keeps registers
// R15 - soft clear self-clears next management clock
// R16 - station orders reset bit release carefully
// R17 - lane a/b drive boost field, resets 11
// R18 - lane a/b local boost override bit
// R19 - first fill symbol nine bits, reset K28.5
// R20 - access by clause 22 frames on mdc

module smc_regs #(
    parameter logic [15:0] ID_OUI_HIGH = 16'h1234, // arbitrary value
    parameter logic [5:0] ID_OUI_LOW = 6'h15, // arbitrary value
    parameter logic [5:0] ID_MODEL = 6'h2a, // arbitrary value
    parameter logic [3:0] ID_REVISION = 4'h3 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [4:0] phy_addr,
    input wire smc_pkg::smc_pins_t pins,
    output smc_pkg::smc_ctrl_t ctl
);
    import smc_pkg::*;

    // ------------------------------------------------------------------
    // state and reset image
    // ------------------------------------------------------------------
    localparam smc_ctrl_t CTL_RESET = '{
        lane_on: 8'h00,
        tx_individual_clock: 1'b0,
        code_error_report: 1'b0,
        par_out_en: 1'b0,
        comma_search_en: 1'b0,
        coding_en: 1'b0,
        if_mode: 2'h0,
        boost_ab: 2'h0,
        boost_override_ab: 1'b0,
        fill_symbol_ab: 9'h000,
        logic_clear: 1'b1
    };

    localparam smc_state_t STATE_RESET = '{
        mdc_prev: 1'b0,
        phase: PH_PREAMBLE,
        cnt: 6'h00,
        hdr: 12'h000,
        shift: 16'h0000,
        rd_hit: 1'b0,
        wr_hit: 1'b0,
        lane_en: LANE_EN_RESET,
        gcfg: GLOBAL_CFG_RESET,
        boost: BOOST_AB_RESET,
        mdio_out: 1'b0,
        mdio_oe: 1'b0,
        ctl: CTL_RESET
    };

    smc_state_t s;
    smc_state_t next_s;
    logic mdc_rise;
    logic wr_commit;
    logic [15:0] rdata;

    // ------------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------------

    // register contents by address; holes read as zero
    always_comb begin
        case (s.hdr[4:0])
            REG_ID_HIGH: rdata = ID_OUI_HIGH; // see R1
            REG_ID_LOW: rdata = {ID_OUI_LOW, ID_MODEL, ID_REVISION}; // see R2
            REG_EXT_STATUS: rdata = EXT_STATUS_VALUE; // see R3
            REG_LANE_EN: rdata = s.lane_en;
            REG_GLOBAL_CFG: rdata = s.gcfg;
            REG_BOOST_AB: rdata = s.boost;
            default: rdata = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------
    // frame engine, register update and effective controls
    // ------------------------------------------------------------------

    // mdc is taken as synchronous; act once per rising edge
    assign mdc_rise = mdc & ~s.mdc_prev; // see R20
    assign wr_commit = mdc_rise && s.phase == PH_WRITE && s.wr_hit
        && s.cnt[3:0] == DATA_LAST;

    always_comb begin
        next_s = s;
        next_s.mdc_prev = mdc;

        // soft clear drops on the management edge after it was set
        if (mdc_rise && s.gcfg[CFG_SOFT_CLR]) begin
            next_s.gcfg[CFG_SOFT_CLR] = 1'b0; // see R15
        end

        if (mdc_rise) begin
            case (s.phase)
                PH_PREAMBLE: begin
                    if (mdio_in) begin
                        if (s.cnt != PREAMBLE_BITS) begin
                            next_s.cnt = s.cnt + 6'd1;
                        end
                    end else if (s.cnt == PREAMBLE_BITS) begin
                        next_s.phase = PH_START; // first start bit
                    end else begin
                        next_s.cnt = 6'h00;
                    end
                end
                PH_START: begin
                    next_s.cnt = 6'h00;
                    next_s.phase = mdio_in ? PH_HEADER : PH_PREAMBLE;
                end
                PH_HEADER: begin
                    // opcode, device address, register address
                    next_s.hdr = {s.hdr[10:0], mdio_in};
                    next_s.cnt = s.cnt + 6'd1;
                    if (s.cnt[3:0] == HEADER_LAST) begin
                        next_s.cnt = 6'h00;
                        // device address sits in bits 8:4 before last shift
                        next_s.rd_hit = s.hdr[10:9] == OP_READ
                            && s.hdr[8:4] == phy_addr; // see R20
                        next_s.wr_hit = s.hdr[10:9] == OP_WRITE
                            && s.hdr[8:4] == phy_addr; // see R20
                        next_s.phase = PH_TURN;
                        if (!(s.hdr[10:9] == OP_READ
                            || s.hdr[10:9] == OP_WRITE)) begin
                            next_s.phase = PH_PREAMBLE;
                        end
                    end
                end
                PH_TURN: begin
                    // two turnaround bits; a read drives zero on the second
                    next_s.cnt = s.cnt + 6'd1;
                    if (s.cnt == 6'h00) begin
                        next_s.mdio_oe = s.rd_hit;
                        next_s.mdio_out = 1'b0;
                        next_s.shift = rdata;
                    end else begin
                        next_s.cnt = 6'h00;
                        next_s.phase = s.rd_hit ? PH_READ : PH_WRITE;
                        next_s.mdio_out = s.shift[15]; // see R20
                        next_s.shift = {s.shift[14:0], 1'b0};
                    end
                end
                PH_READ: begin
                    // sixteen data bits, most significant first
                    next_s.cnt = s.cnt + 6'd1;
                    next_s.mdio_out = s.shift[15];
                    next_s.shift = {s.shift[14:0], 1'b0};
                    if (s.cnt[3:0] == DATA_LAST) begin
                        next_s.mdio_oe = 1'b0;
                        next_s.mdio_out = 1'b0;
                        next_s.cnt = 6'h00;
                        next_s.phase = PH_PREAMBLE;
                    end
                end
                PH_WRITE: begin
                    next_s.cnt = s.cnt + 6'd1;
                    next_s.shift = {s.shift[14:0], mdio_in};
                    if (s.cnt[3:0] == DATA_LAST) begin
                        next_s.cnt = 6'h00;
                        next_s.phase = PH_PREAMBLE;
                    end
                end
                default: begin
                    next_s.phase = PH_PREAMBLE;
                    next_s.mdio_oe = 1'b0;
                end
            endcase
        end

        // masked write: read-only and reserved bits keep zero
        if (wr_commit) begin
            case (s.hdr[4:0])
                REG_LANE_EN: begin
                    next_s.lane_en = {s.shift[14:0], mdio_in}
                        & LANE_EN_WMASK; // see R4, R7
                end
                REG_GLOBAL_CFG: begin
                    next_s.gcfg = {s.shift[14:0], mdio_in}
                        & GLOBAL_CFG_WMASK; // see R7
                end
                REG_BOOST_AB: begin
                    next_s.boost = {s.shift[14:0], mdio_in}
                        & BOOST_AB_WMASK; // see R7, R17, R19
                end
                default: begin
                    next_s.boost = s.boost; // id and status drop writes
                end
            endcase
        end

        // effective controls from register bits; lane, tx style, error report, gate, coding and mode also use pins
        next_s.ctl.lane_on = next_s.lane_en[LANE_LSB +: 8]
            & {8{pins.enable_pin}}; // see R5
        next_s.ctl.tx_individual_clock = next_s.gcfg[CFG_TX_STYLE]
            | pins.tx_clock_select_pin; // see R8
        next_s.ctl.code_error_report = next_s.gcfg[CFG_CODE_ERR]
            | pins.code_error_report_pin; // see R9
        next_s.ctl.par_out_en = next_s.gcfg[CFG_OUT_GATE]
            & pins.enable_pin; // see R10
        next_s.ctl.comma_search_en = next_s.gcfg[CFG_COMMA]; // see R11
        next_s.ctl.coding_en = next_s.gcfg[CFG_CODING]
            | pins.coding_select_pin; // see R12
        next_s.ctl.if_mode = next_s.gcfg[CFG_PIN_MODE_OVERRIDE]
            ? next_s.gcfg[CFG_MODE_LSB +: 2] : pins.mode_pins; // see R13
        next_s.ctl.boost_ab = next_s.boost[BOOST_LSB +: 2]; // see R17
        next_s.ctl.boost_override_ab = next_s.boost[BOOST_OVR]; // see R18
        next_s.ctl.fill_symbol_ab = next_s.boost[FILL_LSB +: 9]; // see R19
        // datapath clear only; the registers above are untouched
        next_s.ctl.logic_clear = next_s.gcfg[CFG_SOFT_CLR]; // see R14
    end

    // state register; hardware reset also clears the datapath
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign mdio_out = s.mdio_out;
    assign mdio_oe = s.mdio_oe;
    assign ctl = s.ctl;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_lane_gate: assert property ( // see R5
        !$past(pins.enable_pin) |-> ctl.lane_on == 8'h00)
        else $error("lane enabled while enable pin low");

    chk_reserved_zero: assert property ( // see R7
        s.lane_en[7:0] == 8'h00 && s.gcfg[13:10] == 4'h0
        && s.gcfg[2:0] == 3'h0 && s.boost[15:12] == 4'h0)
        else $error("reserved register bits not zero");

    chk_soft_selfclear: assert property ( // see R15
        s.gcfg[CFG_SOFT_CLR] && mdc_rise && !wr_commit
        |=> !s.gcfg[CFG_SOFT_CLR])
        else $error("soft clear did not self-clear");

    chk_clear_output: assert property ( // see R14
        $rose(s.gcfg[CFG_SOFT_CLR]) |-> ctl.logic_clear
        && $stable(s.lane_en) && $stable(s.boost))
        else $error("soft clear not driven or registers lost");

    chk_tx_style: assert property ( // see R8
        !$past(rst) |-> ctl.tx_individual_clock
        == (s.gcfg[CFG_TX_STYLE] | $past(pins.tx_clock_select_pin)))
        else $error("tx clock style wrong");

    chk_coding_err: assert property ( // see R9, R12
        !$past(rst) |->
        ctl.coding_en == (s.gcfg[CFG_CODING] | $past(pins.coding_select_pin))
        && ctl.code_error_report
        == (s.gcfg[CFG_CODE_ERR] | $past(pins.code_error_report_pin)))
        else $error("coding or error report enable wrong");

    chk_output_gate: assert property ( // see R10
        ctl.par_out_en |-> s.gcfg[CFG_OUT_GATE] && $past(pins.enable_pin))
        else $error("parallel output enabled without gate");

    chk_mode_select: assert property ( // see R13
        !$past(rst) |->
        ctl.if_mode == (s.gcfg[CFG_PIN_MODE_OVERRIDE] ? s.gcfg[5:4]
        : $past(pins.mode_pins)))
        else $error("interface mode source wrong");

    chk_status_zero: assert property ( // see R3
        s.phase == PH_TURN && s.cnt == 6'h01
        && s.hdr[4:0] == REG_EXT_STATUS |-> s.shift == 16'h0000)
        else $error("extended status not zero");

    chk_read_drive: assert property ( // see R20
        s.phase == PH_READ |-> s.mdio_oe)
        else $error("read data not driven");

    chk_id_high: assert property ( // see R1
        s.phase == PH_TURN && s.cnt == 6'h01
        && s.hdr[4:0] == REG_ID_HIGH |-> s.shift == ID_OUI_HIGH)
        else $error("identifier high word wrong");

    chk_id_low: assert property ( // see R2
        s.phase == PH_TURN && s.cnt == 6'h01 && s.hdr[4:0] == REG_ID_LOW
        |-> s.shift == {ID_OUI_LOW, ID_MODEL, ID_REVISION})
        else $error("identifier low word wrong");

    // first edge after reset: registers show their reset image
    chk_reset_image: assert property ( // see R4, R17, R19
        $past(rst) |-> s.lane_en == LANE_EN_RESET
        && s.gcfg == GLOBAL_CFG_RESET && s.boost == BOOST_AB_RESET)
        else $error("registers not at reset values after reset");

    chk_regs_kept: assert property ( // see R14
        !wr_commit |=> $stable(s.lane_en) && $stable(s.boost))
        else $error("register changed without a write");

    chk_comma_follow: assert property ( // see R11
        !$past(rst) |-> ctl.comma_search_en == s.gcfg[CFG_COMMA])
        else $error("comma search enable wrong");

    chk_boost_follow: assert property ( // see R17, R18, R19
        !$past(rst) |-> ctl.boost_ab == s.boost[BOOST_LSB +: 2]
        && ctl.boost_override_ab == s.boost[BOOST_OVR]
        && ctl.fill_symbol_ab == s.boost[FILL_LSB +: 9])
        else $error("lane a/b boost or fill symbol wrong");

    chk_line_idle: assert property ( // see R20
        s.phase == PH_PREAMBLE || s.phase == PH_START
        || s.phase == PH_HEADER |-> !s.mdio_oe)
        else $error("data line driven outside read data");

    chk_phy_miss: assert property ( // see R20
        s.phase == PH_TURN && s.cnt == 6'h01 && !s.rd_hit |-> !s.mdio_oe)
        else $error("line driven for another device");

    cov_read_frame: cover property (s.phase == PH_READ && s.cnt == 6'd15);
    cov_phy_miss: cover property (s.phase == PH_TURN && s.cnt == 6'h01
        && !s.rd_hit);
    cov_write_cfg: cover property (wr_commit
        && s.hdr[4:0] == REG_GLOBAL_CFG);
    cov_soft_clear: cover property ($fell(s.gcfg[CFG_SOFT_CLR]));
    cov_pin_mode_override: cover property (s.gcfg[CFG_PIN_MODE_OVERRIDE]);

endmodule : smc_regs

// ---- tb/serdes_mgmt_config_regs_tb_top.sv ----
`timescale 1ns/1ps
module serdes_mgmt_config_regs_tb_top;
    import smc_pkg::*;

    typedef struct packed {
        logic [1:0] op;
        logic [4:0] pa;
        logic [4:0] ra;
        logic [15:0] wd;
        logic [15:0] exp;
    } smc_row_t;

    localparam logic [4:0] MY = 5'h05;
    localparam logic [4:0] BAD = 5'h06;
    localparam logic [15:0] ID_H = 16'h0c3a; // arbitrary value
    localparam logic [5:0] ID_OL = 6'h2d; // arbitrary value
    localparam logic [5:0] ID_MD = 6'h11; // arbitrary value
    localparam logic [3:0] ID_RV = 4'h6; // arbitrary value

    logic clk_sys;
    logic rst;
    logic mdc;
    logic mdio_wire;
    logic mdio_out;
    logic mdio_oe;
    smc_pins_t pins;
    smc_ctrl_t ctl;
    smc_ctrl_t rc;
    int errors;
    int checks_done;
    int cycles;
    logic [15:0] rd;
    smc_row_t rows [0:19];

    smc_regs #(.ID_OUI_HIGH(ID_H), .ID_OUI_LOW(ID_OL), .ID_MODEL(ID_MD),
        .ID_REVISION(ID_RV)) dut (.clk_sys(clk_sys), .rst(rst), .mdc(mdc),
        .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .phy_addr(MY), .pins(pins), .ctl(ctl));

    smc_station st (.clk_sys(clk_sys), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .mdc(mdc), .mdio_wire(mdio_wire));

    // ------------------------------------------------------------------
    // compare tasks and closing report
    // ------------------------------------------------------------------
    task automatic cmp16(input string what, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp16

    task automatic cmp_ctl(input smc_ctrl_t e, input smc_ctrl_t g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] ctl expected %h seen %h", e, g);
        end
    endtask : cmp_ctl

    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // effective controls from register contents and pins
    function automatic smc_ctrl_t exp_ctl(input logic [15:0] g,
        input smc_pins_t p);
        smc_ctrl_t c;
        c = '0;
        c.lane_on = 8'ha5 & {8{p.enable_pin}};
        c.tx_individual_clock = g[15] | p.tx_clock_select_pin;
        c.code_error_report = g[14] | p.code_error_report_pin;
        c.par_out_en = g[9] & p.enable_pin;
        c.comma_search_en = g[8];
        c.coding_en = g[7] | p.coding_select_pin;
        c.if_mode = g[6] ? g[5:4] : p.mode_pins;
        c.boost_ab = 2'h3;
        c.boost_override_ab = 1'b1;
        c.fill_symbol_ab = 9'h05a;
        return c;
    endfunction : exp_ctl

    // walk every pin combination against one configuration word
    task automatic check_pins(input logic [15:0] g);
        for (int k = 0; k < 64; k++) begin
            pins = k[5:0];
            repeat (2) @(posedge clk_sys);
            #1;
            cmp_ctl(exp_ctl(g, pins), ctl);
        end
    endtask : check_pins

    // clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rows = '{
            '{OP_READ, MY, REG_ID_HIGH, 16'h0000, ID_H},
            '{OP_READ, MY, REG_ID_LOW, 16'h0000, {ID_OL, ID_MD, ID_RV}},
            '{OP_READ, MY, REG_EXT_STATUS, 16'h0000, 16'h0000},
            '{OP_READ, MY, REG_LANE_EN, 16'h0000, 16'hff00},
            '{OP_READ, MY, REG_GLOBAL_CFG, 16'h0000, 16'h4380},
            '{OP_READ, MY, REG_BOOST_AB, 16'h0000, 16'h0dbc},
            '{OP_WRITE, MY, REG_EXT_STATUS, 16'hffff, 16'h0000},
            '{OP_READ, MY, REG_EXT_STATUS, 16'h0000, 16'h0000},
            '{OP_WRITE, MY, REG_ID_HIGH, 16'h0000, 16'h0000},
            '{OP_READ, MY, REG_ID_HIGH, 16'h0000, ID_H},
            '{OP_WRITE, MY, REG_LANE_EN, 16'ha5ff, 16'h0000},
            '{OP_READ, MY, REG_LANE_EN, 16'h0000, 16'ha500},
            '{OP_WRITE, BAD, REG_LANE_EN, 16'h0000, 16'h0000},
            '{OP_READ, BAD, REG_LANE_EN, 16'h0000, 16'hffff},
            '{OP_WRITE, MY, REG_GLOBAL_CFG, 16'hbcf7, 16'h0000},
            '{OP_READ, MY, REG_GLOBAL_CFG, 16'h0000, 16'h80f0},
            '{OP_WRITE, MY, REG_BOOST_AB, 16'hfe5a, 16'h0000},
            '{OP_READ, MY, REG_BOOST_AB, 16'h0000, 16'h0e5a},
            '{OP_READ, MY, 5'h01, 16'h0000, 16'h0000},
            '{OP_READ, MY, REG_LANE_EN, 16'h0000, 16'ha500}};
        errors = 0;
        checks_done = 0;
        rst = 1'b1;
        pins = '0;
        rc = '0;
        rc.logic_clear = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        cmp_ctl(rc, ctl);
        rst = 1'b0;
        for (int i = 0; i < 20; i++) begin
            st.frame(rows[i].op, rows[i].pa, rows[i].ra, rows[i].wd, rd);
            if (rows[i].op == OP_READ) begin
                cmp16("rd", rows[i].exp, rd);
            end
        end
        check_pins(16'h80f0);
        st.frame(OP_WRITE, MY, REG_GLOBAL_CFG, 16'h4300, rd);
        check_pins(16'h4300);
        // soft clear: pulse seen, registers kept, bit drops at next mdc rise
        st.frame(OP_WRITE, MY, REG_GLOBAL_CFG, 16'h4308, rd);
        cmp16("logic_clear", 16'h0001, {15'h0000, ctl.logic_clear});
        st.frame(OP_READ, MY, REG_GLOBAL_CFG, 16'h0000, rd);
        cmp16("cfg after clear", 16'h4300, rd);
        cmp16("logic_clear", 16'h0000, {15'h0000, ctl.logic_clear});
        st.frame(OP_READ, MY, REG_LANE_EN, 16'h0000, rd);
        cmp16("lane kept", 16'ha500, rd);
        // second reset in mid-run reloads the registers
        @(posedge clk_sys);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        cmp_ctl(rc, ctl);
        rst = 1'b0;
        st.frame(OP_READ, MY, REG_LANE_EN, 16'h0000, rd);
        cmp16("lane reset", 16'hff00, rd);
        report_and_stop();
    end
endmodule : serdes_mgmt_config_regs_tb_top

// ---- tb/smc_station.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// management station model: drives mdc and frames on the data line
// ----------------------------------------------------------------------
module smc_station (
    input wire logic clk_sys,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output logic mdc,
    output logic mdio_wire
);
    import smc_pkg::*;

    logic st_en;
    logic st_bit;

    // line level: device first, then station, else the pull-up
    assign mdio_wire = mdio_oe ? mdio_out : (st_en ? st_bit : 1'b1);

    // clock stands low and the line is released between frames
    initial begin
        mdc = 1'b0;
        st_en = 1'b0;
        st_bit = 1'b0;
    end

    // one bit: two cycles low, sample the line, two cycles high
    task automatic put_bit(input logic b, input logic drv, output logic seen);
        mdc = 1'b0;
        st_en = drv;
        st_bit = b;
        repeat (2) @(posedge clk_sys);
        #1;
        seen = mdio_wire;
        mdc = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : put_bit

    // whole frame; lane and reset bits change only between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic rd_op;
        logic seen;
        hdr = {2'b01, op, pa, ra};
        rd_op = (op == OP_READ);
        rd = 16'h0000;
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < 32; i++) begin
            put_bit(1'b1, 1'b1, seen);
        end
        for (int i = 13; i >= 0; i--) begin
            put_bit(hdr[i], 1'b1, seen);
        end
        put_bit(1'b1, !rd_op, seen);
        put_bit(1'b0, !rd_op, seen);
        for (int i = 15; i >= 0; i--) begin
            put_bit(wd[i], !rd_op, seen);
            rd[i] = seen;
        end
        mdc = 1'b0;
        st_en = 1'b0;
    endtask : frame
endmodule : smc_station
